/* File: src/ffm_detector.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - latch on: flags freeze once event_active sets; reading source clears them
// - latch off: source flags follow the detection result every sample
// - freefall mode: event is AND of low-g on all enabled axes
// - motion mode: event is OR of high-g on enabled axes
// - axis enable bit includes or excludes that axis from comparison
// - while a latched event is held, new axis events do not update source
// - axis event and polarity flags read zero when the axis is disabled
// - per-axis event flag is one when a qualifying event hits that axis
// - polarity flag: zero for positive, one for negative acceleration
// - event_active gated by interrupt enable and routing gives the interrupt
// - source register is read-only and resets to zero
// - clear mode one: debounce counter cleared when condition is false
// - clear mode zero: counter decrements by one, stops at zero
// - clear mode acts the same for common and per-axis thresholds
// - common threshold is 7-bit unsigned, 63 mg per count, resets zero
// - all configuration resets to zero: freefall, unlatched, axes off
// - low-g: below threshold qualifies; high-g: above threshold qualifies
// - per-axis limit enable selects each axis own 13-bit threshold
// - event sets when counter reaches target; counter never exceeds it
module ffm_detector (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic [ffm_pkg::SAMPLE_W-1:0] x_sample,
  input wire logic [ffm_pkg::SAMPLE_W-1:0] y_sample,
  input wire logic [ffm_pkg::SAMPLE_W-1:0] z_sample,
  input wire logic [ffm_pkg::STEP_W-1:0] common_step_counts,
  input wire logic int_enable,
  input wire logic int_route,
  output logic event_active,
  output logic irq_line1,
  output logic irq_line2
);

  // ---------------- register group ----------------
  logic [7:0] config_q;
  logic [7:0] config_d;
  logic [7:0] limit_q;
  logic [7:0] limit_d;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [6:0] upper_q [3];
  logic [6:0] upper_d [3];
  logic [2:0] upper_flag_q;
  logic [2:0] upper_flag_d;
  logic [5:0] lower_q [3];
  logic [5:0] lower_d [3];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic src_read;
  logic [6:0] src_q;
  logic [2:0] axis_en;
  logic [7:0] src_view;

  assign axis_en = {config_q[ffm_pkg::CFG_Z_EN_BIT], config_q[ffm_pkg::CFG_Y_EN_BIT],
                    config_q[ffm_pkg::CFG_X_EN_BIT]};

  // disabled axes read zero regardless of stored state
  always_comb begin
    src_view = 8'h00;
    src_view[ffm_pkg::SRC_ACTIVE_BIT] = src_q[6];
    src_view[ffm_pkg::SRC_Z_EVENT_BIT] = src_q[5] & axis_en[2];
    src_view[ffm_pkg::SRC_Z_SIGN_BIT] = src_q[4] & axis_en[2];
    src_view[ffm_pkg::SRC_Y_EVENT_BIT] = src_q[3] & axis_en[1];
    src_view[ffm_pkg::SRC_Y_SIGN_BIT] = src_q[2] & axis_en[1];
    src_view[ffm_pkg::SRC_X_EVENT_BIT] = src_q[1] & axis_en[0];
    src_view[ffm_pkg::SRC_X_SIGN_BIT] = src_q[0] & axis_en[0];
  end

  assign src_read = reg_rd && (reg_addr == ffm_pkg::ADDR_SOURCE);

  always_comb begin
    config_d = config_q;
    limit_d = limit_q;
    count_d = count_q;
    upper_d = upper_q;
    upper_flag_d = upper_flag_q;
    lower_d = lower_q;
    rdata_d = 8'h00;
    // source address has no write branch, so writes leave it alone
    if (reg_wr) begin
      if (reg_addr == ffm_pkg::ADDR_CONFIG) begin
        config_d = {reg_wdata[7:3], 3'h0};
      end else if (reg_addr == ffm_pkg::ADDR_LIMIT) begin
        limit_d = reg_wdata;
      end else if (reg_addr == ffm_pkg::ADDR_COUNT) begin
        count_d = reg_wdata;
      end else if (reg_addr == ffm_pkg::ADDR_X_UPPER) begin
        upper_flag_d[0] = reg_wdata[ffm_pkg::UPPER_FLAG_BIT];
        upper_d[0] = reg_wdata[6:0];
      end else if (reg_addr == ffm_pkg::ADDR_X_LOWER) begin
        lower_d[0] = reg_wdata[7:ffm_pkg::LOWER_SHIFT];
      end else if (reg_addr == ffm_pkg::ADDR_Y_UPPER) begin
        upper_flag_d[1] = reg_wdata[ffm_pkg::UPPER_FLAG_BIT];
        upper_d[1] = reg_wdata[6:0];
      end else if (reg_addr == ffm_pkg::ADDR_Y_LOWER) begin
        lower_d[1] = reg_wdata[7:ffm_pkg::LOWER_SHIFT];
      end else if (reg_addr == ffm_pkg::ADDR_Z_UPPER) begin
        upper_d[2] = reg_wdata[6:0];
      end else if (reg_addr == ffm_pkg::ADDR_Z_LOWER) begin
        lower_d[2] = reg_wdata[7:ffm_pkg::LOWER_SHIFT];
      end
    end
    if (reg_rd) begin
      if (reg_addr == ffm_pkg::ADDR_CONFIG) begin
        rdata_d = config_q;
      end else if (reg_addr == ffm_pkg::ADDR_SOURCE) begin
        rdata_d = src_view;
      end else if (reg_addr == ffm_pkg::ADDR_LIMIT) begin
        rdata_d = limit_q;
      end else if (reg_addr == ffm_pkg::ADDR_COUNT) begin
        rdata_d = count_q;
      end else if (reg_addr == ffm_pkg::ADDR_X_UPPER) begin
        rdata_d = {upper_flag_q[0], upper_q[0]};
      end else if (reg_addr == ffm_pkg::ADDR_X_LOWER) begin
        rdata_d = {lower_q[0], 2'h0};
      end else if (reg_addr == ffm_pkg::ADDR_Y_UPPER) begin
        rdata_d = {upper_flag_q[1], upper_q[1]};
      end else if (reg_addr == ffm_pkg::ADDR_Y_LOWER) begin
        rdata_d = {lower_q[1], 2'h0};
      end else if (reg_addr == ffm_pkg::ADDR_Z_UPPER) begin
        rdata_d = {1'b0, upper_q[2]};
      end else if (reg_addr == ffm_pkg::ADDR_Z_LOWER) begin
        rdata_d = {lower_q[2], 2'h0};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      config_q <= ffm_pkg::CONFIG_RESET;
      limit_q <= ffm_pkg::LIMIT_RESET;
      count_q <= ffm_pkg::COUNT_RESET;
      upper_flag_q <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        upper_q[i] <= ffm_pkg::UPPER_RESET;
        lower_q[i] <= ffm_pkg::LOWER_RESET;
      end
      rdata_q <= 8'h00;
    end else begin
      config_q <= config_d;
      limit_q <= limit_d;
      count_q <= count_d;
      upper_flag_q <= upper_flag_d;
      upper_q <= upper_d;
      lower_q <= lower_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------- per-axis comparison ----------------
  logic latch_on;
  logic or_mode;
  logic per_axis_on;
  logic clear_mode;
  logic [15:0] common_counts;
  logic [ffm_pkg::SAMPLE_W-1:0] samples [3];
  logic [2:0] axis_low;
  logic [2:0] axis_high;
  logic [2:0] axis_sign;
  logic [2:0] axis_qual;

  assign latch_on = config_q[ffm_pkg::CFG_LATCH_BIT];
  assign or_mode = config_q[ffm_pkg::CFG_OR_BIT];
  assign per_axis_on = upper_flag_q[0];
  assign clear_mode = limit_q[ffm_pkg::LIM_CLEAR_MODE_BIT];
  // common threshold scaled from 63 mg steps into sample counts
  // both factors widened first so the product is never cut before the cast
  assign common_counts = 16'(limit_q[ffm_pkg::COMMON_W-1:0]) * 16'(common_step_counts);
  assign samples[0] = x_sample;
  assign samples[1] = y_sample;
  assign samples[2] = z_sample;

  for (genvar a = 0; a < 3; a++) begin : g_axis
    logic [ffm_pkg::SAMPLE_W-1:0] mag;
    logic [15:0] lim;
    assign axis_sign[a] = samples[a][ffm_pkg::SAMPLE_W-1];
    assign mag = axis_sign[a] ? ffm_pkg::SAMPLE_W'(~samples[a] + 1'b1) : samples[a];
    assign lim = per_axis_on ? {3'h0, upper_q[a], lower_q[a]} : common_counts;
    assign axis_low[a] = axis_en[a] && ({2'h0, mag} < lim);
    assign axis_high[a] = axis_en[a] && ({2'h0, mag} > lim);
    assign axis_qual[a] = or_mode ? axis_high[a] : axis_low[a];
  end

  logic cond;

  // freefall needs at least one enabled axis
  assign cond = or_mode ? |axis_high
                        : ((|axis_en) && &(axis_low | ~axis_en));

  // ---------------- debounce and source group ----------------
  logic [ffm_pkg::COUNT_W-1:0] dbc_q;
  logic [ffm_pkg::COUNT_W-1:0] dbc_d;
  logic det_q;
  logic det_d;
  logic [6:0] src_d;
  logic held;
  logic [6:0] fresh;
  logic irq1_d;
  logic irq2_d;
  logic irq1_q;
  logic irq2_q;

  always_comb begin
    dbc_d = dbc_q;
    det_d = det_q;
    if (sample_valid) begin
      if (cond) begin
        if (dbc_q < count_q) begin
          dbc_d = dbc_q + 1'b1;
        end
      end else if (clear_mode) begin
        dbc_d = '0;
      end else if (dbc_q != '0) begin
        dbc_d = dbc_q - 1'b1;
      end
      det_d = cond && (dbc_d == count_q);
    end
  end

  always_comb begin
    fresh = 7'h00;
    fresh[6] = det_d;

    // per-axis flags only show while the combined event is detected
    for (int a = 0; a < 3; a++) begin
      fresh[2 * a + 1] = axis_qual[a] & det_d;
      fresh[2 * a] = axis_qual[a] & axis_sign[a] & det_d;
    end

    held = latch_on && src_q[6];
    src_d = src_q;
    // a new event in the clearing cycle wins over the read clear
    if (sample_valid && (!held || src_read)) begin
      src_d = fresh;
    end else if (held && src_read) begin
      src_d = ffm_pkg::SOURCE_RESET;
    end else if (!latch_on && sample_valid) begin
      src_d = fresh;
    end
    irq1_d = src_d[6] && int_enable && !int_route;
    irq2_d = src_d[6] && int_enable && int_route;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dbc_q <= '0;
      det_q <= 1'b0;
      src_q <= ffm_pkg::SOURCE_RESET;
      irq1_q <= 1'b0;
      irq2_q <= 1'b0;
    end else begin
      dbc_q <= dbc_d;
      det_q <= det_d;
      src_q <= src_d;
      irq1_q <= irq1_d;
      irq2_q <= irq2_d;
    end
  end

  assign event_active = src_q[6];
  assign irq_line1 = irq1_q;
  assign irq_line2 = irq2_q;

endmodule

/* File: src/ffm_pkg.sv */
package ffm_pkg;
  // register offsets
  localparam logic [7:0] ADDR_CONFIG = 8'h15;
  localparam logic [7:0] ADDR_SOURCE = 8'h16;
  localparam logic [7:0] ADDR_LIMIT = 8'h17;
  localparam logic [7:0] ADDR_COUNT = 8'h18;
  localparam logic [7:0] ADDR_X_UPPER = 8'h73;
  localparam logic [7:0] ADDR_X_LOWER = 8'h74;
  localparam logic [7:0] ADDR_Y_UPPER = 8'h75;
  localparam logic [7:0] ADDR_Y_LOWER = 8'h76;
  localparam logic [7:0] ADDR_Z_UPPER = 8'h77;
  localparam logic [7:0] ADDR_Z_LOWER = 8'h78;
  // config field positions
  localparam int CFG_LATCH_BIT = 7;
  localparam int CFG_OR_BIT = 6;
  localparam int CFG_Z_EN_BIT = 5;
  localparam int CFG_Y_EN_BIT = 4;
  localparam int CFG_X_EN_BIT = 3;
  // source field positions
  localparam int SRC_ACTIVE_BIT = 7;
  localparam int SRC_Z_EVENT_BIT = 5;
  localparam int SRC_Z_SIGN_BIT = 4;
  localparam int SRC_Y_EVENT_BIT = 3;
  localparam int SRC_Y_SIGN_BIT = 2;
  localparam int SRC_X_EVENT_BIT = 1;
  localparam int SRC_X_SIGN_BIT = 0;
  // limit register field positions
  localparam int LIM_CLEAR_MODE_BIT = 7;
  localparam int UPPER_FLAG_BIT = 7;
  localparam int LOWER_SHIFT = 2;
  // widths
  localparam int SAMPLE_W = 14;
  localparam int AXIS_LIMIT_W = 13;
  localparam int COMMON_W = 7;
  localparam int STEP_W = 9;
  localparam int COUNT_W = 8;
  // reset values
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] LIMIT_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [6:0] UPPER_RESET = 7'h00;
  localparam logic [5:0] LOWER_RESET = 6'h00;
  localparam logic [6:0] SOURCE_RESET = 7'h00;
endpackage

/* File: tb/ffm_detector_bench.sv */
`timescale 1ns/1ns
module ffm_detector_bench;
  logic mclk, rst, sv, ien, irt, reg_wr, reg_rd, ea, irq1, irq2, cond;
  logic [13:0] s [3];
  logic [7:0] reg_addr, reg_wdata, reg_rdata, cfg, lim, got, src, nsrc;
  logic [2:0] hit;
  logic [31:0] seed = 32'h98e6;
  int num_errors = 0;
  int total_checks = 0;
  int thr [3];
  int cnt, tgt, mag;
  ffm_detector ffm_detector_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sv), .x_sample(s[0]), .y_sample(s[1]),
    .z_sample(s[2]), .common_step_counts(9'h008), .int_enable(ien), .int_route(irt), .event_active(ea),
    .irq_line1(irq1), .irq_line2(irq2));
  ffm_host ffm_host_inst (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  function automatic logic [31:0] rnd();
    repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    sv = 1'b0;
    ien = 1'b0;
    irt = 1'b0;
    s = '{default: 14'h0000};
    for (int p = 0; p < 12; p++) begin
      rst <= 1'b1;
      repeat (p == 0 ? 10 : 2) @(posedge mclk);
      rst <= 1'b0;
      ffm_host_inst.wr(8'h16, 8'hff);
      ffm_host_inst.wr(8'h14, 8'hff);
      for (int a = 8'h14; a <= 8'h18; a++) begin
        ffm_host_inst.rd(8'(a), got);
        chk(got, 8'h00);
      end
      cfg = 8'(rnd()) & 8'hf8;
      // corner: motion mode with every axis off must never raise an event
      if (p == 2) cfg = 8'h40;
      lim = 8'(rnd()) & 8'h8f;
      tgt = p % 4;
      ien <= seed[0];
      irt <= seed[1];
      ffm_host_inst.wr(8'h15, cfg);
      ffm_host_inst.wr(8'h17, lim);
      ffm_host_inst.wr(8'h18, 8'(tgt));
      for (int i = 0; i < 3; i++) begin
        thr[i] = p[0] ? int'(rnd() & 32'h7f) : lim[6:0] * 8;
        ffm_host_inst.wr(8'(8'h73 + 2 * i), {(i == 0) && p[0], 6'h00, thr[i][6]});
        ffm_host_inst.wr(8'(8'h74 + 2 * i), {thr[i][5:0], 2'b00});
      end
      ffm_host_inst.rd(8'h15, got);
      chk(got, cfg);
      cnt = 0;
      src = 8'h00;
      for (int j = 0; j < 12; j++) begin
        @(posedge mclk);
        nsrc = 8'h00;
        for (int i = 0; i < 3; i++) begin
          // first sample sits exactly on the threshold
          got = (j == 0) ? 8'(thr[i]) : 8'(rnd());
          s[i] <= {{6{got[7]}}, got};
          mag = got[7] ? 256 - int'(got) : int'(got);
          hit[i] = cfg[6] ? mag > thr[i] : mag < thr[i];
          nsrc[2 * i + 1] = hit[i] && cfg[3 + i];
          nsrc[2 * i] = hit[i] && cfg[3 + i] && got[7];
        end
        cond = cfg[6] ? |(hit & cfg[5:3]) : (cfg[5:3] != 3'h0) && ((hit | ~cfg[5:3]) == 3'h7);
        if (cond) cnt = (cnt < tgt) ? cnt + 1 : cnt;
        else cnt = (lim[7] || cnt == 0) ? 0 : cnt - 1;
        nsrc[7:6] = {cond && cnt == tgt, 1'b0};
        if (!nsrc[7]) nsrc = 8'h00;
        if (!cfg[7] || !src[7]) src = nsrc;
        sv <= 1'b1;
        @(posedge mclk);
        sv <= 1'b0;
        #1;
        chk({7'h00, ea}, {7'h00, src[7]});
        chk({6'h00, irq2, irq1}, {6'h00, src[7] && ien && irt, src[7] && ien && !irt});
        if (!j[0]) begin
          ffm_host_inst.rd(8'h16, got);
          chk(got, src);
          if (cfg[7]) src = 8'h00;
        end
      end
      $display("phase %0d done", p);
    end
    final_report();
  end
endmodule

/* File: tb/ffm_detector_props.sv */
`timescale 1ns/1ns
module ffm_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic event_active,
  input wire logic irq_line1,
  input wire logic irq_line2
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic src_rd;
  assign src_rd = reg_rd && reg_addr == 8'h16;
  // shadow of the config register
  always_comb begin
    cfg_d = cfg_q;
    if (reg_wr && reg_addr == 8'h15) begin
      cfg_d = reg_wdata;
    end
  end
  always_ff @(posedge mclk) begin
    cfg_q <= rst ? 8'h00 : cfg_d;
  end
  a_irq_gate: assert property ((irq_line1 || irq_line2) |-> event_active && !(irq_line1 && irq_line2))
    else $error("irq without event");
  a_live_hold: assert property (!cfg_q[7] && !sample_valid && !reg_wr |=> $stable(event_active))
    else $error("event moved without sample");
  a_latch_hold: assert property (cfg_q[7] && event_active && !reg_rd && !reg_wr |=> event_active)
    else $error("latched event dropped");
  a_read_clear: assert property (cfg_q[7] && src_rd && !sample_valid && !reg_wr |=> !event_active)
    else $error("source read did not clear");
  a_src_read: assert property (src_rd |=> reg_rdata[7] == $past(event_active) && !reg_rdata[6])
    else $error("source read mismatch");
  a_axis_off: assert property (src_rd |=> (reg_rdata[5:0] & ~{{2{$past(cfg_q[5])}}, {2{$past(cfg_q[4])}},
    {2{$past(cfg_q[3])}}}) == 6'h00)
    else $error("flag of disabled axis set");
  a_no_axes: assert property (sample_valid && !cfg_q[7] && cfg_q[5:3] == 3'h0 |=> !event_active)
    else $error("event with no axis enabled");
  a_reset_clear: assert property (disable iff (1'b0) rst |=> !event_active && !irq_line1 && !irq_line2
    && reg_rdata == 8'h00)
    else $error("outputs not cleared by reset");
endmodule
bind ffm_detector ffm_props ffm_props_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
  .event_active(event_active), .irq_line1(irq_line1), .irq_line2(irq_line2));

/* File: tb/ffm_host.sv */
`timescale 1ns/1ns
module ffm_host (
  input wire logic mclk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    // released lines do not keep the last value
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule
